//--- core/twmr_core.sv
`timescale 1ns/1ps
`default_nettype none
module twmr_core
#(
	parameter logic [7:0] QTR = twmr_pkg::QTR_CYCLES
)
(
	// system
	input  wire logic                   clk_sys,
	input  wire logic                   sys_rst,
	// register bus
	input  wire twmr_pkg::twmr_wb_req_t wb_req,
	output var  twmr_pkg::twmr_wb_rsp_t wb_rsp,
	// bus clock line
	input  wire logic                   scl_i,
	output logic                        scl_o,
	output logic                        scl_oe,
	// bus data line
	input  wire logic                   sda_i,
	output logic                        sda_o,
	output logic                        sda_oe
);
	import twmr_pkg::*;

	twmr_state_t st_ff;
	twmr_state_t nxt_st;
	logic        clr_flag;
	logic        set_flag;
	logic        step;
	logic        last;
	logic        scl_hi;
	logic        bus_start;
	logic        bus_stop;
	logic [31:0] wd;

	// own address or enabled general call, write direction only
	function automatic logic addr_hit(input logic [7:0] pkt, input logic [7:0] own);
		addr_hit = (~pkt[0] & (pkt[7:1] == own[7:1])) | ((pkt == 8'h00) & own[OWN_GCE]);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		nxt_st = st_ff;
		clr_flag = 1'b0;
		set_flag = 1'b0;
		wd = wb_req.dat;

		// two-flop synchronisers, third stage for edge detection
		nxt_st.scl_m = scl_i;
		nxt_st.scl_s = st_ff.scl_m;
		nxt_st.scl_p = st_ff.scl_s;
		nxt_st.sda_m = sda_i;
		nxt_st.sda_s = st_ff.sda_m;
		nxt_st.sda_p = st_ff.sda_s;

		// quarter-bit enable pulse
		nxt_st.tick = 1'b0;
		if (st_ff.divcnt >= QTR - 8'h01)
		begin
			nxt_st.divcnt = 8'h00;
			nxt_st.tick = 1'b1;
		end
		else
			nxt_st.divcnt = st_ff.divcnt + 8'h01;

		// bus monitor sees every START and STOP, our own included
		scl_hi = st_ff.scl_s & st_ff.scl_p;
		bus_start = scl_hi & st_ff.sda_p & ~st_ff.sda_s;
		bus_stop = scl_hi & ~st_ff.sda_p & st_ff.sda_s;
		if (bus_start)
			nxt_st.busy = 1'b1;
		if (bus_stop)
			nxt_st.busy = 1'b0;

		// wishbone slave: one ack per request, dropped the cycle after
		nxt_st.rsp.ack = 1'b0;
		if (wb_req.cyc & wb_req.stb & ~st_ff.rsp.ack)
		begin
			nxt_st.rsp.ack = 1'b1;
			nxt_st.rsp.dat = 32'h0000_0000;
			case ({wb_req.adr[4:2], 2'b00})
				REG_CTRL:
				begin
					nxt_st.rsp.dat[7:0] = {st_ff.flag, st_ff.aen, st_ff.sta, st_ff.sto,
						st_ff.wcol, st_ff.en, 1'b0, st_ff.ie};
					if (wb_req.we & wb_req.sel[0])
					begin
						clr_flag = wd[CTL_FLAG];
						nxt_st.aen = wd[CTL_AEN];
						nxt_st.sta = wd[CTL_STA];
						nxt_st.sto = wd[CTL_STO];
						nxt_st.en = wd[CTL_EN];
						nxt_st.ie = wd[CTL_IE];
					end
				end
				REG_STAT:
					nxt_st.rsp.dat[7:0] = st_ff.code & STAT_MASK;
				REG_DATA:
				begin
					nxt_st.rsp.dat[7:0] = st_ff.data;
					if (wb_req.we & wb_req.sel[0])
					begin
						// the shifter may be busy, so a write outside the flag is refused
						if (st_ff.flag)
						begin
							nxt_st.data = wd[7:0];
							nxt_st.wcol = 1'b0;
						end
						else
							nxt_st.wcol = 1'b1;
					end
				end
				REG_OWN:
				begin
					nxt_st.rsp.dat[7:0] = st_ff.own;
					if (wb_req.we & wb_req.sel[0])
						nxt_st.own = wd[7:0];
				end
				default:
					nxt_st.rsp.dat = 32'h0000_0000;
			endcase
		end

		// bit engine: phase 2 waits for the line to read high (stretching)
		step = st_ff.tick & ~((st_ff.phase == 2'h2) & ~st_ff.scl_s);
		last = step & (st_ff.phase == 2'h3);
		if (step)
			nxt_st.phase = st_ff.phase + 2'h1;

		unique case (st_ff.fsm)
			S_IDLE:
			begin
				nxt_st.owned = 1'b0;
				nxt_st.sda_oe = 1'b0;
				nxt_st.scl_oe = 1'b0;
				nxt_st.phase = 2'h0;
				// start only on a free, quiet bus
				if (st_ff.sta & ~st_ff.flag & ~st_ff.busy & st_ff.scl_s & st_ff.sda_s)
					nxt_st.fsm = S_START;
				else if (bus_start & st_ff.aen)
				begin
					nxt_st.fsm = S_SADR;
					nxt_st.bitn = 4'h0;
				end
			end
			S_START:
				if (last)
				begin
					nxt_st.code = st_ff.owned ? ST_RSTART : ST_START;
					nxt_st.owned = 1'b1;
					set_flag = 1'b1;
					nxt_st.fsm = S_HOLD;
				end
			S_XMIT:
				if (last)
				begin
					if (st_ff.bitn < LAST_BIT)
					begin
						// released high but read low: another master won
						if (~st_ff.sda_oe & ~st_ff.sda_s)
						begin
							nxt_st.code = ST_ARB;
							nxt_st.owned = 1'b0;
							nxt_st.sda_oe = 1'b0;
							set_flag = 1'b1;
							nxt_st.fsm = S_HOLD;
						end
						else
						begin
							nxt_st.shreg = {st_ff.shreg[6:0], 1'b1};
							nxt_st.bitn = st_ff.bitn + 4'h1;
						end
					end
					else
					begin
						if (!st_ff.is_addr)
							nxt_st.code = st_ff.sda_s ? ST_DW_NAK : ST_DW_ACK;
						else if (st_ff.rw)
							nxt_st.code = st_ff.sda_s ? ST_AR_NAK : ST_AR_ACK;
						else
							nxt_st.code = st_ff.sda_s ? ST_AW_NAK : ST_AW_ACK;
						set_flag = 1'b1;
						nxt_st.fsm = S_HOLD;
					end
				end
			S_RECV:
				if (last)
				begin
					if (st_ff.bitn < LAST_BIT)
					begin
						nxt_st.shreg = {st_ff.shreg[6:0], st_ff.sda_s};
						nxt_st.bitn = st_ff.bitn + 4'h1;
					end
					else if (~st_ff.rx_ack & ~st_ff.sda_s)
					begin
						nxt_st.code = ST_ARB;
						nxt_st.owned = 1'b0;
						set_flag = 1'b1;
						nxt_st.fsm = S_HOLD;
					end
					else
					begin
						nxt_st.data = st_ff.shreg;
						nxt_st.code = st_ff.rx_ack ? ST_DR_ACK : ST_DR_NAK;
						set_flag = 1'b1;
						nxt_st.fsm = S_HOLD;
					end
				end
			S_HOLD:
				// next action is chosen from the status once the flag is cleared
				if (~st_ff.flag)
				begin
					nxt_st.phase = 2'h0;
					nxt_st.bitn = 4'h0;
					unique case (st_ff.code)
						ST_START, ST_RSTART:
						begin
							nxt_st.shreg = st_ff.data;
							nxt_st.rw = st_ff.data[0];
							nxt_st.is_addr = 1'b1;
							nxt_st.fsm = S_XMIT;
						end
						ST_AR_ACK, ST_DR_ACK:
						begin
							nxt_st.rx_ack = st_ff.aen;
							nxt_st.fsm = S_RECV;
						end
						ST_AW_ACK, ST_AW_NAK, ST_DW_ACK, ST_DW_NAK, ST_AR_NAK, ST_DR_NAK:
							if (st_ff.sto)
								nxt_st.fsm = S_STOP;
							else if (st_ff.sta)
								nxt_st.fsm = S_START;
							else if (st_ff.code == ST_AR_NAK || st_ff.code == ST_DR_NAK)
								nxt_st.fsm = S_IDLE;
							else
							begin
								nxt_st.shreg = st_ff.data;
								nxt_st.is_addr = 1'b0;
								nxt_st.fsm = S_XMIT;
							end
						default:
						begin
							nxt_st.code = ST_NONE;
							nxt_st.fsm = S_IDLE;
						end
					endcase
				end
			S_STOP:
				if (last)
				begin
					nxt_st.sto = 1'b0;
					nxt_st.owned = 1'b0;
					nxt_st.code = ST_NONE;
					nxt_st.fsm = S_IDLE;
				end
			S_SADR:
			begin
				nxt_st.scl_oe = 1'b0;
				if (bus_stop)
					nxt_st.fsm = S_IDLE;
				else if (st_ff.scl_s & ~st_ff.scl_p & (st_ff.bitn < LAST_BIT))
				begin
					nxt_st.shreg = {st_ff.shreg[6:0], st_ff.sda_s};
					nxt_st.bitn = st_ff.bitn + 4'h1;
				end
				else if (~st_ff.scl_s & st_ff.scl_p & (st_ff.bitn == LAST_BIT))
				begin
					if (addr_hit(st_ff.shreg, st_ff.own) & st_ff.aen)
					begin
						nxt_st.sda_oe = 1'b1;
						nxt_st.bitn = st_ff.bitn + 4'h1;
					end
					else
						nxt_st.fsm = S_IDLE;
				end
				else if (~st_ff.scl_s & st_ff.scl_p & (st_ff.bitn > LAST_BIT))
				begin
					nxt_st.sda_oe = 1'b0;
					nxt_st.code = (st_ff.shreg == 8'h00) ? ST_SL_GC : ST_SL_OWN;
					set_flag = 1'b1;
					nxt_st.fsm = S_HOLD;
				end
			end
			default:
				nxt_st.fsm = S_IDLE;
		endcase

		// line drive follows the next state and phase
		unique case (nxt_st.fsm)
			S_START:
			begin
				nxt_st.scl_oe = (nxt_st.phase == 2'h0) & nxt_st.owned;
				nxt_st.sda_oe = nxt_st.phase[1];
			end
			S_XMIT:
			begin
				nxt_st.scl_oe = ~nxt_st.phase[1];
				nxt_st.sda_oe = (nxt_st.bitn < LAST_BIT) & ~nxt_st.shreg[7];
			end
			S_RECV:
			begin
				nxt_st.scl_oe = ~nxt_st.phase[1];
				nxt_st.sda_oe = (nxt_st.bitn == LAST_BIT) & nxt_st.rx_ack;
			end
			S_STOP:
			begin
				nxt_st.scl_oe = (nxt_st.phase == 2'h0);
				nxt_st.sda_oe = (nxt_st.phase != 2'h3);
			end
			S_HOLD:
				nxt_st.scl_oe = 1'b1;
			default:
				nxt_st.scl_oe = nxt_st.scl_oe;
		endcase

		// hardware set wins over a clear in the same cycle
		nxt_st.flag = (st_ff.flag & ~clr_flag) | set_flag;

		// disabled: release both lines and forget the bus
		if (~nxt_st.en)
		begin
			nxt_st.fsm = S_IDLE;
			nxt_st.scl_oe = 1'b0;
			nxt_st.sda_oe = 1'b0;
			nxt_st.owned = 1'b0;
			nxt_st.busy = 1'b0;
			nxt_st.code = ST_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register, synchronous reset
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			st_ff <= '0;
			st_ff.fsm <= S_IDLE;
			st_ff.code <= ST_NONE;
			st_ff.data <= DATA_RST;
			st_ff.own <= OWN_RST;
			{st_ff.flag, st_ff.aen, st_ff.sta, st_ff.sto, st_ff.wcol, st_ff.en, st_ff.ie} <=
				{CTRL_RST[7:2], CTRL_RST[0]};
			// idle bus reads high; avoids a false edge after reset
			{st_ff.scl_m, st_ff.scl_s, st_ff.scl_p} <= 3'h7;
			{st_ff.sda_m, st_ff.sda_s, st_ff.sda_p} <= 3'h7;
		end
		else
			st_ff <= nxt_st;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, open-drain lines only ever pull low
	assign wb_rsp = st_ff.rsp;
	assign scl_oe = st_ff.scl_oe;
	assign sda_oe = st_ff.sda_oe;
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;

endmodule
`default_nettype wire

//--- core/twmr_pkg.sv
package twmr_pkg;

	// register byte offsets
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STAT = 5'h04;
	localparam logic [4:0] REG_DATA = 5'h08;
	localparam logic [4:0] REG_OWN  = 5'h0C;

	// control register bit positions, and the general call enable bit of the own address register
	localparam int CTL_FLAG = 7;
	localparam int CTL_AEN  = 6;
	localparam int CTL_STA  = 5;
	localparam int CTL_STO  = 4;
	localparam int CTL_WCOL = 3;
	localparam int CTL_EN   = 2;
	localparam int CTL_IE   = 0;
	localparam int OWN_GCE  = 0;

	// status codes
	localparam logic [7:0] ST_START  = 8'h08;
	localparam logic [7:0] ST_RSTART = 8'h10;
	localparam logic [7:0] ST_AW_ACK = 8'h18;
	localparam logic [7:0] ST_AW_NAK = 8'h20;
	localparam logic [7:0] ST_DW_ACK = 8'h28;
	localparam logic [7:0] ST_DW_NAK = 8'h30;
	localparam logic [7:0] ST_ARB    = 8'h38;
	localparam logic [7:0] ST_AR_ACK = 8'h40;
	localparam logic [7:0] ST_AR_NAK = 8'h48;
	localparam logic [7:0] ST_DR_ACK = 8'h50;
	localparam logic [7:0] ST_DR_NAK = 8'h58;
	localparam logic [7:0] ST_SL_OWN = 8'h60;
	localparam logic [7:0] ST_SL_GC  = 8'h70;
	localparam logic [7:0] ST_NONE   = 8'hF8;
	localparam logic [7:0] STAT_MASK = 8'hF8;

	// reset values and timing
	localparam logic [7:0] CTRL_RST   = 8'h00;
	localparam logic [7:0] OWN_RST    = 8'h00;
	localparam logic [7:0] DATA_RST   = 8'hFF;
	localparam logic [7:0] QTR_CYCLES = 8'h02;
	localparam logic [3:0] LAST_BIT   = 4'h8;

	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_START = 7'h02,
		S_XMIT  = 7'h04,
		S_RECV  = 7'h08,
		S_HOLD  = 7'h10,
		S_STOP  = 7'h20,
		S_SADR  = 7'h40
	} twmr_fsm_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [4:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} twmr_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} twmr_wb_rsp_t;

	typedef struct packed {
		twmr_fsm_t    fsm;
		logic [1:0]   phase;
		logic [3:0]   bitn;
		logic [7:0]   divcnt;
		logic         tick;
		logic         flag;
		logic         aen;
		logic         sta;
		logic         sto;
		logic         wcol;
		logic         en;
		logic         ie;
		logic [7:0]   code;
		logic [7:0]   data;
		logic [7:0]   own;
		logic [7:0]   shreg;
		logic         owned;
		logic         busy;
		logic         is_addr;
		logic         rw;
		logic         rx_ack;
		logic         scl_oe;
		logic         sda_oe;
		logic         scl_m;
		logic         scl_s;
		logic         scl_p;
		logic         sda_m;
		logic         sda_s;
		logic         sda_p;
		twmr_wb_rsp_t rsp;
	} twmr_state_t;

endpackage

//--- verif/test_twmr_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_twmr_core;
	import twmr_pkg::*;
	typedef struct packed {logic we; logic [4:0] adr; logic [7:0] wd; logic [7:0] exp;} twmr_row_t;
	logic clk_sys, sys_rst, scl_i, sda_i, pull, mack, hit, ext_scl, ext_sda;
	logic scl_o, scl_oe, sda_o, sda_oe;
	logic [7:0] q;
	twmr_wb_req_t req;
	twmr_wb_rsp_t rsp;
	twmr_row_t rows [0:8];
	int n_mismatch, checks_done;
	// open-drain lines with pull-ups
	assign scl_i = ~scl_oe & ext_scl;
	assign sda_i = ~sda_oe & ~pull & ext_sda;
	twmr_core twmr_core_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_req(req), .wb_rsp(rsp),
		.scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
	twmr_slave_model twmr_slave_model_inst (.scl(scl_i), .sda(sda_i), .pull(pull), .mack(mack));
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			$display("[FAIL] %s exp %h got %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	// one classic cycle; request held until ack is sampled
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		req <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, d}};
		// no cycle count assumed; only the watchdog ends a hung wait
		do
			@(posedge clk_sys);
		while (rsp.ack !== 1'b1);
		q = rsp.dat[7:0];
		check("dat high", 8'h00, rsp.dat[31:24] | rsp.dat[23:16] | rsp.dat[15:8]);
		req <= '0;
	endtask
	task automatic poll(input int b, input logic v);
		int k;
		k = 0;
		do
		begin
			bus(1'b0, REG_CTRL, 8'h00);
			k++;
		end
		while (q[b] !== v && k < 200);
		hit = (k < 200);
	endtask
	task automatic stat(input logic [7:0] e, input string nm);
		poll(CTL_FLAG, 1'b1);
		bus(1'b0, REG_STAT, 8'h00);
		check(nm, e, q);
	endtask
	// another master sends a write address; the device acks and stretches, then clear and stop
	task automatic ext_addr(input logic [7:0] b, input logic [7:0] e, input string nm);
		int i;
		logic ackd;
		bus(1'b1, REG_CTRL, 8'h44);
		ext_sda <= 1'b0;
		repeat (4) @(posedge clk_sys);
		for (i = 8; i >= 0; i--)
		begin
			ext_scl <= 1'b0;
			repeat (4) @(posedge clk_sys);
			ext_sda <= (i == 0) ? 1'b1 : b[i - 1];
			repeat (4) @(posedge clk_sys);
			ext_scl <= 1'b1;
			repeat (8) @(posedge clk_sys);
		end
		ackd = ~sda_i;
		ext_scl <= 1'b0;
		check("slave ack", 8'h01, {7'h0, ackd});
		stat(e, nm);
		bus(1'b1, REG_CTRL, 8'h84);
		ext_sda <= 1'b0;
		repeat (4) @(posedge clk_sys);
		ext_scl <= 1'b1;
		repeat (4) @(posedge clk_sys);
		ext_sda <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic finish_test;
		if (n_mismatch == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// hang guard, far beyond the expected few thousand cycles
	initial
	begin
		repeat (30000) @(posedge clk_sys);
		n_mismatch++;
		finish_test();
	end
	initial
	begin
		sys_rst = 1'b1;
		ext_scl = 1'b1;
		ext_sda = 1'b1;
		req = '0;
		n_mismatch = 0;
		checks_done = 0;
		rows = '{'{1'b0, REG_CTRL, 8'h00, 8'h00}, '{1'b0, REG_STAT, 8'h00, 8'hF8}, '{1'b0, REG_DATA, 8'h00, 8'hFF},
			'{1'b0, REG_OWN, 8'h00, 8'h00}, '{1'b1, REG_OWN, 8'h65, 8'h00}, '{1'b0, REG_OWN, 8'h00, 8'h65},
			'{1'b1, REG_STAT, 8'h00, 8'h00}, '{1'b0, REG_STAT, 8'h00, 8'hF8}, '{1'b0, 5'h10, 8'h00, 8'h00}};
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		// reset values, read-only status, own address, unmapped offset
		foreach (rows[i])
		begin
			bus(rows[i].we, rows[i].adr, rows[i].wd);
			if (!rows[i].we)
				check("reg", rows[i].exp, q);
		end
		// read transfer: acked byte, then refused last byte
		bus(1'b1, REG_CTRL, 8'hA4);
		stat(ST_START, "start");
		bus(1'b1, REG_DATA, 8'h55);
		bus(1'b1, REG_CTRL, 8'hC4);
		stat(ST_AR_ACK, "addr ack");
		bus(1'b1, REG_CTRL, 8'hC4);
		stat(ST_DR_ACK, "byte ack");
		bus(1'b0, REG_DATA, 8'h00);
		check("byte 1", 8'hC3, q);
		check("ack out", 8'h00, {7'h0, mack});
		bus(1'b1, REG_CTRL, 8'h84);
		stat(ST_DR_NAK, "byte nak");
		bus(1'b0, REG_DATA, 8'h00);
		check("byte 2", 8'hC4, q);
		check("nak out", 8'h01, {7'h0, mack});
		// repeated start to an address nobody answers, then stop
		bus(1'b1, REG_CTRL, 8'hA4);
		stat(ST_RSTART, "rstart");
		bus(1'b1, REG_DATA, 8'h63);
		bus(1'b1, REG_CTRL, 8'h84);
		stat(ST_AR_NAK, "addr nak");
		bus(1'b1, REG_CTRL, 8'h94);
		poll(CTL_STO, 1'b0);
		check("stop ctrl", 8'h04, q);
		bus(1'b0, REG_STAT, 8'h00);
		check("stop stat", ST_NONE, q);
		// another master addresses the device, then the general call
		ext_addr(8'h64, ST_SL_OWN, "own addr");
		ext_addr(8'h00, ST_SL_GC, "general call");
		// data write without the flag collides
		bus(1'b1, REG_DATA, 8'h12);
		bus(1'b0, REG_CTRL, 8'h00);
		check("collide", 8'h0C, q);
		// start request with the interface off must never run
		bus(1'b1, REG_CTRL, 8'hA0);
		poll(CTL_FLAG, 1'b1);
		check("off start", 8'h00, {7'h0, hit});
		bus(1'b0, REG_STAT, 8'h00);
		check("off stat", ST_NONE, q);
		finish_test();
	end
endmodule
`default_nettype wire

//--- verif/twmr_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module twmr_core_sva
#(
	parameter logic [7:0] QTR = twmr_pkg::QTR_CYCLES
)
(
	// system
	input wire logic clk_sys,
	input wire logic sys_rst,
	// register bus
	input wire twmr_pkg::twmr_wb_req_t wb_req,
	input wire twmr_pkg::twmr_wb_rsp_t wb_rsp,
	// bus lines
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe
);
	import twmr_pkg::*;
	logic [7:0] lo_ff;
	logic [7:0] nxt_lo;
	logic rd_c;
	logic rd_s;
	// reads are judged while the master still holds its address
	assign rd_c = wb_rsp.ack && !wb_req.we && wb_req.adr == REG_CTRL;
	assign rd_s = wb_rsp.ack && !wb_req.we && wb_req.adr == REG_STAT;
	// clock-low length, saturating so a long hold never wraps
	always_comb nxt_lo = !scl_oe ? 8'h00 : (lo_ff == 8'hFF ? lo_ff : lo_ff + 8'h01);
	always_ff @(posedge clk_sys) lo_ff <= sys_rst ? 8'h00 : nxt_lo;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////
	chk_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack too long");
	chk_ack_cause: assert property ($rose(wb_rsp.ack) |-> $past(wb_req.stb)) else $error("ack without request");
	chk_stat_mask: assert property (rd_s |-> wb_rsp.dat[2:0] == 3'h0) else $error("status low bits set");
	chk_hold_scl: assert property (rd_c && wb_rsp.dat[CTL_FLAG] |-> scl_oe) else $error("clock free");
	chk_off_idle: assert property (rd_c && !wb_rsp.dat[CTL_EN] |-> !scl_oe && !sda_oe)
		else $error("lines driven while off");
	chk_start_form: assert property ($rose(sda_oe) && !scl_oe && scl_i |-> sda_oe throughout (1'b1 ##[2:8] scl_oe))
		else $error("bad start");
	chk_stop_form: assert property ($fell(sda_oe) && !scl_oe |-> (!scl_oe && !sda_oe)[*2])
		else $error("bad stop");
	chk_scl_low: assert property ($fell(scl_oe) |-> lo_ff >= 8'(2 * QTR)) else $error("clock low too short");
	chk_open_drain: assert property (!scl_o && !sda_o) else $error("line driven high");
	// main scenarios
	cover property ($rose(sda_oe) && !scl_oe);
	cover property ($fell(sda_oe) && !scl_oe);
	cover property (rd_s && wb_rsp.dat[7:0] == ST_DR_NAK);
	cover property (rd_s && wb_rsp.dat[7:0] == ST_SL_GC);
endmodule
bind twmr_core twmr_core_sva #(.QTR(QTR)) twmr_core_sva_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.wb_req(wb_req), .wb_rsp(wb_rsp), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

//--- verif/twmr_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module twmr_slave_model
#(
	parameter logic [6:0] ADDR = 7'h2A,
	parameter logic [7:0] FIRST = 8'hC3
)
(
	// resolved bus lines
	input wire logic scl,
	input wire logic sda,
	// data pull-down and last master ack
	output logic pull,
	output logic mack
);
	logic [7:0] sh;
	logic [7:0] tx;
	logic [3:0] n;
	logic adr_ph;
	logic sel;
	logic send;
	logic wrap;
	initial
	begin
		pull = 1'b0;
		mack = 1'b1;
		n = 4'h0;
		adr_ph = 1'b0;
		sel = 1'b0;
		send = 1'b0;
		tx = FIRST;
	end
	// a start restarts framing; the falling clock after it is not a bit.
	// data may fall in the same step as the clock, so look again a little later
	always @(negedge sda)
	begin
		#1;
		if (scl && !sda)
		begin
			n = 4'hF;
			adr_ph = 1'b1;
			send = 1'b0;
			pull = 1'b0;
		end
	end
	// sample on rising clock
	always @(posedge scl)
		if (n < 4'h8)
			sh = {sh[6:0], sda};
		else if (send)
			mack = sda;
	// change data only after the clock falls; released means pulled up
	always @(negedge scl)
	begin
		wrap = (n == 4'h8);
		n = wrap ? 4'h0 : n + 4'h1;
		if (wrap && send && !mack)
			tx = tx + 8'h01;
		if (wrap)
			send = adr_ph ? sel && sh[0] : send && !mack;
		if (wrap)
			adr_ph = 1'b0;
		if (n == 4'h8 && adr_ph)
			sel = (sh[7:1] == ADDR);
		pull = (n == 4'h8) ? adr_ph && sel : send && !tx[3'h7 - n[2:0]];
	end
endmodule
`default_nettype wire
